// File: design/temp_seq_regs.svh
`ifndef TEMP_SEQ_REGS_SVH
`define TEMP_SEQ_REGS_SVH
// byte addresses on apb
`define REG_CONFIG 12'h000
`define REG_COMMAND 12'h004
`define REG_RATE 12'h008
`define REG_STATUS 12'h00c
`define REG_RESULT0 12'h010
`define REG_RESULT1 12'h014
`define REG_RESULT2 12'h018
`define REG_THR_HIGH 12'h01c
`define REG_THR_LOW 12'h020
`define REG_IRQ_STATUS 12'h024
`define REG_IRQ_CLEAR 12'h028
`define REG_IRQ_ENABLE 12'h02c
// field positions
`define CFG_STANDBY_BIT 0
`define CMD_START_BIT 0
`define CMD_ONESHOT_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_STANDBY_BIT 1
`define IRQ_DONE_BIT 0
`define IRQ_HIGH_BIT 1
`define IRQ_LOW_BIT 2
// reset values
`define RATE_RESET 8'h00
`define THR_HIGH_RESET 8'h7f
`define THR_LOW_RESET 8'hc9
// timing
`define CLK_HZ 100000000
`define CHAN_MS 60
`define PERIOD_MS 125
`define CHAN_CYCLES (`CHAN_MS * (`CLK_HZ / 1000))
`define PERIOD_CYCLES (`PERIOD_MS * (`CLK_HZ / 1000))
`endif

// File: design/temp_seq_pkg.sv
package temp_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_SETTLE
  } seq_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic req;
    logic [1:0] chan;
  } adc_req_t;
endpackage

// File: design/cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [WIDTH-1:0] load_i,
  output logic done_o,
  output logic running_o
);
  logic [WIDTH-1:0] count;
  if (WIDTH < 2) begin : g_bad_width
    $error("cycle_timer width too small");
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      running_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      count <= load_i;
      running_o <= 1'b1;
      done_o <= 1'b0;
    end else if (running_o) begin
      done_o <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
      running_o <= (count != {{(WIDTH-1){1'b0}}, 1'b1});
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule // cycle_timer

// File: design/temp_conversion_sequencer.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "temp_seq_regs.svh"
module temp_conversion_sequencer #(
  parameter int CHAN_CYCLES = `CHAN_CYCLES,
  parameter int PERIOD_CYCLES = `PERIOD_CYCLES,
  parameter int RATE_UNIT = `PERIOD_CYCLES
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire temp_seq_pkg::apb_req_t APB_REQ_I,
  output temp_seq_pkg::apb_rsp_t APB_RSP_O,
  output temp_seq_pkg::adc_req_t ADC_REQ_O,
  input wire logic ADC_VALID_I,
  input wire logic [7:0] ADC_DATA_I,
  output logic BUSY_O,
  output logic IRQ_O
);
  import temp_seq_pkg::*;

  // timers are loaded with one less than the span they must time
  if (CHAN_CYCLES < 2) begin : g_bad_chan
    $error("channel window needs at least two cycles");
  end
  if (PERIOD_CYCLES < 3 * CHAN_CYCLES + 1) begin : g_bad_period
    $error("sequence period cannot hold three channel windows");
  end
  if (RATE_UNIT < 1) begin : g_bad_rate
    $error("rate unit must be positive");
  end
  // the idle gap is unit times rate and must fit its 32-bit counter
  if (longint'(RATE_UNIT) * 255 > 64'hffffffff) begin : g_bad_gap
    $error("rate unit too large for the gap counter");
  end

  seq_state_t state;
  logic standby;
  logic [7:0] rate;
  logic [7:0] thr_high;
  logic [7:0] thr_low;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [7:0] shadow [3];
  logic [7:0] result [3];
  logic [1:0] chan;
  logic chan_got;
  logic single;
  logic [31:0] gap;
  logic chan_start, chan_done;
  logic per_start, per_done;
  logic start_cmd, oneshot_cmd, seq_go, seq_end;
  logic wr, rd;
  logic ev_done, ev_high, ev_low;

  assign wr = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
  assign rd = APB_REQ_I.psel & ~APB_REQ_I.penable & ~APB_REQ_I.pwrite;
  assign start_cmd = wr & (APB_REQ_I.paddr == `REG_COMMAND) &
                     APB_REQ_I.pwdata[`CMD_START_BIT];
  assign oneshot_cmd = wr & (APB_REQ_I.paddr == `REG_COMMAND) &
                       APB_REQ_I.pwdata[`CMD_ONESHOT_BIT];

  // free-running restart needs standby low; one-shot ignores it
  assign seq_go = (state == ST_IDLE) &&
                  (oneshot_cmd ||
                   (!standby && (start_cmd || (gap == 32'h0 && !single))));
  assign seq_end = (state == ST_SETTLE) && per_done;

  // the channel window and the full period run on separate timers
  cycle_timer #(.WIDTH(32)) chan_timer (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .start_i(chan_start),
    .load_i(32'(CHAN_CYCLES - 1)),
    .done_o(chan_done),
    .running_o()
  );
  cycle_timer #(.WIDTH(32)) period_timer (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .start_i(per_start),
    .load_i(32'(PERIOD_CYCLES - 1)),
    .done_o(per_done),
    .running_o()
  );
  assign per_start = seq_go;
  assign chan_start = seq_go ||
                      (state == ST_CONVERT && chan_done && chan != 2'd2);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      chan <= 2'd0;
      single <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (seq_go) begin
            state <= ST_CONVERT;
            chan <= 2'd0;
            single <= oneshot_cmd;
          end
        end
        ST_CONVERT: begin
          if (chan_done) begin
            if (chan == 2'd2) begin
              state <= ST_SETTLE;
            end else begin
              chan <= chan + 2'd1;
            end
          end
        end
        ST_SETTLE: begin
          if (per_done) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // a standby write mid-sequence lets the sequence finish cleanly
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      gap <= 32'h0;
    end else if (seq_end) begin
      gap <= RATE_UNIT * rate;
    end else if (state == ST_IDLE && gap != 32'h0) begin
      gap <= gap - 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ADC_REQ_O <= '0;
      chan_got <= 1'b0;
    end else begin
      ADC_REQ_O.req <= chan_start;
      ADC_REQ_O.chan <= seq_go ? 2'd0 : chan + 2'd1;
      if (chan_start) chan_got <= 1'b0;
      else if (ADC_VALID_I) chan_got <= 1'b1;
    end
  end

  // samples go to a shadow copy; readers see only whole sets
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      shadow <= '{default: 8'h00};
      result <= '{default: 8'h00};
    end else begin
      if (ADC_VALID_I && state == ST_CONVERT && !chan_got)
        shadow[chan] <= ADC_DATA_I;
      if (seq_end) result <= shadow;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) BUSY_O <= 1'b0;
    else BUSY_O <= seq_go || (state != ST_IDLE && !seq_end);
  end

  // signed compare on every channel at the end of each sequence
  always_comb begin
    ev_done = seq_end;
    ev_high = 1'b0;
    ev_low = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (seq_end && $signed(shadow[i]) > $signed(thr_high))
        ev_high = 1'b1;
      if (seq_end && $signed(shadow[i]) < $signed(thr_low))
        ev_low = 1'b1;
    end
  end

  // set wins over clear in the same cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status &
                     ~((wr && APB_REQ_I.paddr == `REG_IRQ_CLEAR) ?
                       APB_REQ_I.pwdata[2:0] : 3'h0)) |
                    {ev_low, ev_high, ev_done};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) IRQ_O <= 1'b0;
    else IRQ_O <= |(irq_status & irq_enable);
  end

  // register writes are accepted in standby too
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      standby <= 1'b0;
      rate <= `RATE_RESET;
      thr_high <= `THR_HIGH_RESET;
      thr_low <= `THR_LOW_RESET;
      irq_enable <= 3'h0;
    end else if (wr) begin
      case (APB_REQ_I.paddr)
        `REG_CONFIG: standby <= APB_REQ_I.pwdata[`CFG_STANDBY_BIT];
        `REG_RATE: rate <= APB_REQ_I.pwdata[7:0];
        `REG_THR_HIGH: thr_high <= APB_REQ_I.pwdata[7:0];
        `REG_THR_LOW: thr_low <= APB_REQ_I.pwdata[7:0];
        `REG_IRQ_ENABLE: irq_enable <= APB_REQ_I.pwdata[2:0];
        default: ;
      endcase
    end
  end

  // zero-wait slave: pready high in every access phase
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      APB_RSP_O <= '0;
    end else begin
      APB_RSP_O.pready <= APB_REQ_I.psel & ~APB_REQ_I.penable;
      APB_RSP_O.pslverr <= 1'b0;
      if (rd) begin
        case (APB_REQ_I.paddr)
          `REG_CONFIG: APB_RSP_O.prdata <= {31'h0, standby};
          `REG_RATE: APB_RSP_O.prdata <= {24'h0, rate};
          `REG_STATUS: APB_RSP_O.prdata <= {30'h0, standby, BUSY_O};
          `REG_RESULT0: APB_RSP_O.prdata <= {24'h0, result[0]};
          `REG_RESULT1: APB_RSP_O.prdata <= {24'h0, result[1]};
          `REG_RESULT2: APB_RSP_O.prdata <= {24'h0, result[2]};
          `REG_THR_HIGH: APB_RSP_O.prdata <= {24'h0, thr_high};
          `REG_THR_LOW: APB_RSP_O.prdata <= {24'h0, thr_low};
          `REG_IRQ_STATUS: APB_RSP_O.prdata <= {29'h0, irq_status};
          `REG_IRQ_ENABLE: APB_RSP_O.prdata <= {29'h0, irq_enable};
          default: APB_RSP_O.prdata <= 32'h0;
        endcase
      end
    end
  end
  // no fan logic lives here, standby cannot reach it
endmodule // temp_conversion_sequencer

// File: tb/temp_seq_monitor.sv
`timescale 1ns/10ps
`include "temp_seq_regs.svh"
module temp_seq_monitor #(
  parameter int CHAN_CYCLES = 10,
  parameter int PERIOD_CYCLES = 40
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire temp_seq_pkg::apb_req_t APB_REQ_I,
  input wire temp_seq_pkg::apb_rsp_t APB_RSP_O,
  input wire temp_seq_pkg::adc_req_t ADC_REQ_O,
  input wire logic BUSY_O
);
  import temp_seq_pkg::*;
  localparam int LEN = PERIOD_CYCLES - 1;
  logic go;
  assign go = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite &&
    APB_REQ_I.paddr == `REG_COMMAND && APB_REQ_I.pwdata[`CMD_ONESHOT_BIT];
  logic sby;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) sby <= 1'b0;
    else if (APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite &&
             APB_REQ_I.paddr == `REG_CONFIG)
      sby <= APB_REQ_I.pwdata[`CFG_STANDBY_BIT];
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  property p_oneshot;
    go && !BUSY_O |=> BUSY_O;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("no start");
  property p_first;
    $rose(BUSY_O) |-> ADC_REQ_O.req && ADC_REQ_O.chan == 2'h0;
  endproperty
  a_first: assert property (p_first) else $error("bad first");
  property p_ch1;
    ADC_REQ_O.req && ADC_REQ_O.chan == 2'h0 |->
      ##CHAN_CYCLES ADC_REQ_O.req && ADC_REQ_O.chan == 2'h1;
  endproperty
  a_ch1: assert property (p_ch1) else $error("bad chan 1");
  property p_ch2;
    ADC_REQ_O.req && ADC_REQ_O.chan == 2'h1 |->
      ##CHAN_CYCLES ADC_REQ_O.req && ADC_REQ_O.chan == 2'h2;
  endproperty
  a_ch2: assert property (p_ch2) else $error("bad chan 2");
  property p_quiet;
    ADC_REQ_O.req |=> !ADC_REQ_O.req [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("short window");
  property p_idle;
    !BUSY_O |-> !ADC_REQ_O.req;
  endproperty
  a_idle: assert property (p_idle) else $error("idle request");
  property p_len;
    $rose(BUSY_O) |-> ##LEN BUSY_O ##1 !BUSY_O;
  endproperty
  a_len: assert property (p_len) else $error("bad busy");
  property p_standby;
    sby && !BUSY_O && !go |=> !BUSY_O;
  endproperty
  a_standby: assert property (p_standby) else $error("standby run");
  property p_ready;
    APB_REQ_I.psel && !APB_REQ_I.penable |=>
      APB_RSP_O.pready ##1 !APB_RSP_O.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad pready");
endmodule // temp_seq_monitor
bind temp_conversion_sequencer temp_seq_monitor #(
  .CHAN_CYCLES(CHAN_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)
) temp_seq_monitor_i (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O), .ADC_REQ_O(ADC_REQ_O),
  .BUSY_O(BUSY_O));

// File: tb/adc_model.sv
`timescale 1ns/10ps
module adc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire temp_seq_pkg::adc_req_t req_i,
  input wire logic [7:0] off_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  import temp_seq_pkg::*;
  logic [2:0] cnt;
  logic [1:0] chan;
  // latency differs per channel; data toggles outside valid so stale
  // values are never mistaken for a result
  always_ff @(posedge clk_i) begin
    valid_o <= cnt == 3'h1;
    data_o <= (cnt == 3'h1) ? off_i + 8'({chan, 5'h0}) : ~data_o;
    if (rst_i) begin
      cnt <= 3'h0;
    end else if (req_i.req) begin
      cnt <= 3'h2 + {1'b0, req_i.chan};
      chan <= req_i.chan;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule // adc_model

// File: tb/temp_conversion_sequencer_tb.sv
`timescale 1ns/10ps
`include "temp_seq_regs.svh"
module temp_conversion_sequencer_tb;
  import temp_seq_pkg::*;
  logic clk;
  logic rst = 1'b1;
  logic busy;
  logic irq;
  logic vld;
  logic [7:0] dat;
  logic [7:0] off = 8'h0;
  logic [31:0] r;
  apb_req_t rq = '0;
  apb_rsp_t rs;
  adc_req_t ar;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  temp_conversion_sequencer #(.CHAN_CYCLES(10), .PERIOD_CYCLES(40),
    .RATE_UNIT(5)) temp_conversion_sequencer_i (.SYS_CLK_I(clk),
    .RST_I(rst), .APB_REQ_I(rq), .APB_RSP_O(rs), .ADC_REQ_O(ar),
    .ADC_VALID_I(vld), .ADC_DATA_I(dat), .BUSY_O(busy), .IRQ_O(irq));
  adc_model adc_model_i (.clk_i(clk), .rst_i(rst), .req_i(ar),
    .off_i(off), .valid_o(vld), .data_o(dat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    do @(posedge clk); while (rs.pready !== 1'b1);
    r = rs.prdata;
    chk(rs.pslverr, 1'b0);
    rq <= '0;
    @(posedge clk);
  endtask
  task automatic wait_busy(input logic v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== v);
    @(posedge clk);
  endtask
  task automatic t_res(input logic [7:0] o);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, `REG_RESULT0 + 12'(4 * i), 0);
      chk(r[7:0], 8'(o + 8'(32 * i)));
    end
  endtask
  task automatic t_reset;
    apb(1'b0, `REG_THR_HIGH, 0);
    chk(r[7:0], 8'h7f);
    apb(1'b0, `REG_THR_LOW, 0);
    chk(r[7:0], 8'hc9);
    apb(1'b0, 12'h030, 0);
    chk(r, 32'h0);
  endtask
  task automatic t_oneshot;
    off <= 8'h05;
    apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
    apb(1'b1, `REG_COMMAND, 32'h2);
    apb(1'b0, `REG_STATUS, 0);
    chk(r[0], 1'b1);
    apb(1'b0, `REG_RESULT0, 0);
    chk(r[7:0], 8'h00);
    wait_busy(1'b0);
    t_res(8'h05);
    chk(irq, 1'b1);
    apb(1'b1, `REG_IRQ_CLEAR, 32'h7);
    apb(1'b0, `REG_IRQ_STATUS, 0);
    chk(r[0], 1'b0);
  endtask
  task automatic t_standby;
    off <= 8'hf0;
    apb(1'b1, `REG_CONFIG, 32'h1);
    apb(1'b1, `REG_COMMAND, 32'h1);
    apb(1'b0, `REG_STATUS, 0);
    chk(r[1:0], 2'h2);
    apb(1'b1, `REG_THR_LOW, 32'hf8);
    apb(1'b0, `REG_THR_LOW, 0);
    chk(r[7:0], 8'hf8);
    apb(1'b1, `REG_COMMAND, 32'h2);
    wait_busy(1'b0);
    t_res(8'hf0);
    apb(1'b0, `REG_IRQ_STATUS, 0);
    chk(r[2:0], 3'h5);
    // low bit stays set but is masked, so the line must drop
    apb(1'b1, `REG_IRQ_CLEAR, 32'h1);
    repeat (20) @(posedge clk);
    chk(busy, 1'b0);
    chk(irq, 1'b0);
    apb(1'b0, `REG_STATUS, 0);
    chk(r[1:0], 2'h2);
  endtask
  task automatic t_freerun;
    off <= 8'h11;
    apb(1'b1, `REG_RATE, 32'h2);
    apb(1'b1, `REG_CONFIG, 32'h0);
    apb(1'b1, `REG_COMMAND, 32'h1);
    wait_busy(1'b0);
    off <= 8'h22;
    wait_busy(1'b1);
    chk(n > 6 && n < 14, 1'b1);
    apb(1'b0, `REG_RESULT0, 0);
    chk(r[7:0], 8'h11);
    wait_busy(1'b0);
    t_res(8'h22);
    apb(1'b1, `REG_CONFIG, 32'h1);
    wait_busy(1'b0);
    repeat (20) @(posedge clk);
    chk(busy, 1'b0);
  endtask
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_oneshot;
    t_standby;
    t_freerun;
    give_verdict;
  end
endmodule // temp_conversion_sequencer_tb
